// ==== rtl/irqlg_pkg.sv ====
// Functional notes
// R01: second timer overflow sets its flag always
// R02: enabled pending flag vectors to address 8
// R03: disabled source still flags, no vector
// R04: flags driven by pin edge, timer overflows
// R05: flag sets at once, vector not implied
// R06: service routine polls enables and flags
// R07: software orders priority by polling order
// R08: software timer setup sequence, mode 20h
// R09: event wins over same-cycle software clear
// R10: flags stay set until software clears
// R11: no interrupt without global enable, resets 0
// R12: edge select 01 rise, 10 fall, 11 both
// R13: take loads vector, pushes return stack
package irqlg_pkg;
  localparam int          PC_W          = 10;
  localparam logic [9:0]  VECTOR_ADDR   = 10'h008;
  localparam logic [1:0]  EDGE_RSVD     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  localparam logic [1:0]  EDGE_SEL_RST  = 2'h2;
  localparam logic        FLAG_RST      = 1'h0;
  localparam logic        ENABLE_RST    = 1'h0;
  localparam logic        GLOBAL_EN_RST = 1'h0;
  localparam int          SRC_PIN       = 0;
  localparam int          SRC_T1        = 1;
  localparam int          SRC_T2        = 2;
  localparam int          NUM_SRC       = 3;
endpackage

// ==== rtl/irqlg_top.sv ====
`timescale 1ns/1ps
module irqlg_top (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       pinIn,
  input  wire logic [1:0] pin_edge_select,
  input  wire logic       timer1Overflow,
  input  wire logic       timer2Overflow,
  input  wire logic [2:0] flagClear,
  input  wire logic       pin_edge_interrupt_enable,
  input  wire logic       timer1_interrupt_enable,
  input  wire logic       timer2_interrupt_enable,
  input  wire logic       globalEnableSet,
  input  wire logic       globalEnableClear,
  input  wire logic       retiDone,
  output logic            pin_edge_request_flag,
  output logic            timer1_overflow_request_flag,
  output logic            timer2_overflow_request_flag,
  output logic            global_interrupt_enable,
  output logic            vectorTake,
  output logic [9:0]      vectorAddr,
  output logic            stackPush
);
  logic [2:0] pinSync_r;
  logic [2:0] flags_r;
  logic       pinLevel_r;
  logic       globalEn_r;
  logic       take_r;
  logic [2:0] events;
  logic       riseEv;
  logic       fallEv;
  logic       pinEv;
  logic       pending;

  // three stage sync; change counted once stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync_r <= 3'h0;
    end else begin
      pinSync_r <= {pinSync_r[1:0], pinIn};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinLevel_r <= 1'h0;
    end else if (pinSync_r[1] == pinSync_r[2]) begin
      pinLevel_r <= pinSync_r[2];
    end
  end

  assign riseEv = (pinSync_r[1] == pinSync_r[2]) && pinSync_r[2] && !pinLevel_r;
  assign fallEv = (pinSync_r[1] == pinSync_r[2]) && !pinSync_r[2] && pinLevel_r;

  always_comb begin
    unique case (pin_edge_select) // see R12
      irqlg_pkg::EDGE_RISE: pinEv = riseEv;
      irqlg_pkg::EDGE_FALL: pinEv = fallEv;
      irqlg_pkg::EDGE_BOTH: pinEv = riseEv | fallEv;
      default:              pinEv = 1'b0; // reserved code gives no event
    endcase
  end

  assign events = {timer2Overflow, timer1Overflow, pinEv}; // see R04

  // set beats clear; no clear on vector entry or return
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= {3{irqlg_pkg::FLAG_RST}};
    end else begin
      flags_r <= (flags_r & ~flagClear) | events; // see R01 see R05 see R09 see R10
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      globalEn_r <= irqlg_pkg::GLOBAL_EN_RST; // see R11
    end else if (take_r) begin
      globalEn_r <= 1'b0; // blocks nesting until return re-enables
    end else if (globalEnableSet || retiDone) begin
      globalEn_r <= 1'b1;
    end else if (globalEnableClear) begin
      globalEn_r <= 1'b0;
    end
  end

  assign pending = |(flags_r & {timer2_interrupt_enable, timer1_interrupt_enable,
                                pin_edge_interrupt_enable}); // see R02 see R03

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      take_r <= 1'b0;
    end else begin
      take_r <= pending && globalEn_r && !take_r; // see R11
    end
  end

  always_comb begin
    pin_edge_request_flag        = flags_r[irqlg_pkg::SRC_PIN];
    timer1_overflow_request_flag = flags_r[irqlg_pkg::SRC_T1];
    timer2_overflow_request_flag = flags_r[irqlg_pkg::SRC_T2];
    global_interrupt_enable      = globalEn_r;
    vectorTake                   = take_r; // see R13
    stackPush                    = take_r; // see R13
    vectorAddr                   = irqlg_pkg::VECTOR_ADDR; // see R02
  end
endmodule

// ==== bench/irqlg_chk.sv ====
`timescale 1ns/1ps
module irqlg_chk (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       timer2Overflow,
  input wire logic [2:0] flagClear,
  input wire logic       timer2_overflow_request_flag,
  input wire logic       global_interrupt_enable,
  input wire logic       vectorTake,
  input wire logic [9:0] vectorAddr,
  input wire logic       stackPush
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire fl = timer2_overflow_request_flag;
  AST_SET: assert property (timer2Overflow |=> fl) else $error("set");
  AST_SRC: assert property ($rose(fl) |-> $past(timer2Overflow)) else $error("src");
  AST_HOLD: assert property (fl && !flagClear[2] |=> fl) else $error("hold");
  AST_GLB: assert property (vectorTake |-> $past(global_interrupt_enable)) else $error("glb");
  AST_VEC: assert property (vectorTake |-> vectorAddr == 10'h008) else $error("vec");
  AST_PUSH: assert property (vectorTake |-> stackPush) else $error("push");
  AST_ONE: assert property (vectorTake |=> !vectorTake) else $error("one");
  AST_CLR: assert property (flagClear[2] && !timer2Overflow |=> !fl) else $error("clr");
endmodule
bind irqlg_top irqlg_chk u_irqlg_chk (.*);

// ==== bench/irqlg_core_model.sv ====
`timescale 1ns/1ps
module irqlg_core_model (
  input wire logic       core_clk,
  input wire logic       vectorTake,
  input wire logic [2:0] req,
  output logic     [2:0] clr,
  output logic           reti
);
  // lowest pending enabled source wins, polled in isr
  always @(posedge core_clk) begin
    clr  <= vectorTake ? req & (~req + 3'h1) : 3'h0;
    reti <= vectorTake;
  end
endmodule

// ==== bench/irqlg_tb.sv ====
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, arst_n = 0, pinIn = 0, timer1Overflow = 0, timer2Overflow = 0, retiDone;
  logic globalEnableSet = 0, globalEnableClear = 0, pin_edge_interrupt_enable = 0;
  logic timer1_interrupt_enable = 0, timer2_interrupt_enable = 0, vectorTake, stackPush;
  logic pin_edge_request_flag, timer1_overflow_request_flag, timer2_overflow_request_flag;
  logic global_interrupt_enable;
  logic [1:0] pin_edge_select = 2'h1;
  logic [2:0] flagClear, swClr = 3'h0, clr, fl;
  logic [9:0] vectorAddr;
  int bad_count = 0, cmp_count = 0, takes = 0;
  assign fl = {timer2_overflow_request_flag, timer1_overflow_request_flag, pin_edge_request_flag};
  assign flagClear = clr | swClr;
  irqlg_top u_irqlg_top (.*);
  irqlg_core_model u_irqlg_core_model (.core_clk, .vectorTake, .clr, .reti(retiDone),
    .req(fl & {timer2_interrupt_enable, timer1_interrupt_enable, pin_edge_interrupt_enable}));
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) takes += vectorTake;
  initial begin #4000; bad_count++; print_verdict; end
  task step(int n); repeat (n) @(posedge core_clk); #1; endtask
  task chk(logic [2:0] g, e); cmp_count++; if (g !== e) begin bad_count++;
    $display("unexpected at %0t: %h vs %h", $time, g, e); end endtask
  task print_verdict; $display("%0d checks, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish; endtask
  initial begin
    step(2); arst_n = 1; chk(global_interrupt_enable, 0);
    globalEnableSet = 1; step(1); globalEnableSet = 0; timer2Overflow = 1; step(1);
    timer2Overflow = 0; step(4); chk(fl, 3'h4); chk(takes, 0);
    timer2_interrupt_enable = 1; step(4); chk(takes, 1); chk(fl, 0);
    $display("test 1 done");
    globalEnableClear = 1; step(1); globalEnableClear = 0; timer1_interrupt_enable = 1;
    timer1Overflow = 1; step(1); timer1Overflow = 0; step(4); chk(takes, 1);
    globalEnableSet = 1; step(1); globalEnableSet = 0; step(4); chk(takes, 2);
    timer1_interrupt_enable = 0; timer2_interrupt_enable = 0; timer2Overflow = 1; swClr = 3'h4;
    step(1); timer2Overflow = 0; swClr = 0; step(1); chk(fl, 3'h4);
    for (int s = 0; s < 4; s++) begin
      pin_edge_select = s; swClr = 3'h7; step(1); swClr = 0; pinIn = 1; step(6);
      chk(fl[0], s & 1);
      swClr = 3'h7; step(1); swClr = 0; pinIn = 0; step(6); chk(fl[0], s >> 1);
    end
    $display("test 2 done"); print_verdict;
  end
endmodule
